/* File: hdl/msf_pkg.sv */
package msf_pkg;

   // Bus geometry
   localparam int unsigned AXI_ADDR_W = 12;
   localparam int unsigned AXI_DATA_W = 32;
   localparam int unsigned AXI_STRB_W = 4;
   localparam int unsigned REG_IDX_W = 8;
   localparam int unsigned WORD_LSB = 2;
   localparam int unsigned FLAG_W = 16;
   localparam int unsigned CNT_W = 2;

   // Register indices; byte address is four times the index
   localparam logic [REG_IDX_W-1:0] IDX_PROGRESS = 8'h02;
   localparam logic [REG_IDX_W-1:0] IDX_FAULT = 8'h03;
   localparam logic [REG_IDX_W-1:0] IDX_CONTROL = 8'h10;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_STATUS = 8'h11;
   localparam logic [REG_IDX_W-1:0] IDX_IRQ_MASK = 8'h12;

   // Reset values
   localparam logic [FLAG_W-1:0] FAULT_RESET = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_RESET = 2'h0;
   localparam logic [AXI_DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

   // Progress register fields
   localparam int unsigned PROG_MUX_CNT_LSB = 14;
   localparam int unsigned PROG_CUR_A_CNT_LSB = 10;
   localparam int unsigned PROG_CUR_B_CNT_LSB = 8;
   localparam int unsigned PROG_RUNNING_BIT = 1;

   // Fault flag positions
   localparam int unsigned FLT_ANALOG_OV = 15;
   localparam int unsigned FLT_ANALOG_UV = 14;
   localparam int unsigned FLT_IO_OV = 13;
   localparam int unsigned FLT_IO_UV = 12;
   localparam int unsigned FLT_CORE_OV = 11;
   localparam int unsigned FLT_CORE_UV = 10;
   localparam int unsigned FLT_ANALOG_OSC = 9;
   localparam int unsigned FLT_IO_OSC = 8;
   localparam int unsigned FLT_CORE_OSC = 7;
   localparam int unsigned FLT_ANALOG_OTW = 6;
   localparam int unsigned FLT_IO_OTW = 5;
   localparam int unsigned FLT_ANALOG_CL = 4;
   localparam int unsigned FLT_IO_CL = 3;
   localparam int unsigned FLT_GND_A_OPEN = 2;
   localparam int unsigned FLT_GND_B_OPEN = 1;
   localparam int unsigned FLT_DIGITAL_GROUND_OPEN = 0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Control word, low bits of the control register
   typedef struct packed {
      logic standby;
      logic cur_b_en;
      logic cur_a_en;
      logic mux_en;
   } msf_ctrl_t;
   localparam int unsigned CTRL_W = $bits(msf_ctrl_t);
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

   // Event bits, shared by interrupt status and mask
   typedef struct packed {
      logic fault_new;
      logic cur_b_done;
      logic cur_a_done;
      logic mux_seq_done;
   } msf_irq_t;
   localparam int unsigned IRQ_W = $bits(msf_irq_t);
   localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

   // Detector conditions, high while the fault is present
   typedef struct packed {
      logic analog_supply_overvoltage;
      logic analog_supply_undervoltage;
      logic io_supply_overvoltage;
      logic io_supply_undervoltage;
      logic core_supply_overvoltage;
      logic core_supply_undervoltage;
      logic analog_supply_oscillation;
      logic io_supply_oscillation;
      logic core_supply_oscillation;
      logic analog_regulator_overtemp_warn;
      logic io_regulator_overtemp_warn;
      logic analog_regulator_current_limit;
      logic io_regulator_current_limit;
      logic analog_ground_first_open;
      logic analog_ground_second_open;
      logic digital_ground_open;
   } msf_fault_det_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h0,
      WR_ADDR = 2'h1,
      WR_RESP = 2'h3,
      WR_DATA = 2'h2
   } msf_wr_state_t;

   typedef enum logic {
      RD_IDLE = 1'h0,
      RD_RESP = 1'h1
   } msf_rd_state_t;

endpackage : msf_pkg

/* File: hdl/msf_wrap_counter.sv */
`timescale 1ns/1ns
module msf_wrap_counter
   import msf_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clear_i,
   input wire logic step_i,
   output logic [CNT_W-1:0] count_o
);

   logic [CNT_W-1:0] count_q;

   // Clear beats a step in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         count_q <= CNT_RESET;
      end else if (clear_i) begin
         count_q <= CNT_RESET;
      end else if (step_i) begin
         // Natural wrap from top value to zero
         count_q <= count_q + 2'h1;
      end
   end

   assign count_o = count_q;

endmodule : msf_wrap_counter

/* File: hdl/msf_top.sv */
// Contract
// - Bits 15:14 count finished mux sequences, wrapping at top.
// - Mux counter clears when disabled, standby, power-down or reset.
// - Bits 11:10 count current A conversions; clear when off or reset.
// - Bits 9:8 count current B conversions; clear when off or reset.
// - Bit 1 shows mux sequence running; resets to zero.
// - Fault flags active low, reset to ones, write one restores.
// - Bits 15,13,11 drop on analog, io, core overvoltage.
// - Bits 14,12,10 drop on analog, io, core undervoltage.
// - Bits 9,8,7 drop on analog, io, core oscillation.
// - Bits 6,5 drop on analog, io regulator overtemperature warning.
// - Bits 4,3 drop on analog, io regulator current limit.
// - Bits 2,1,0 drop on ground pins found open.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module msf_top
   import msf_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
   input wire logic [AXI_STRB_W-1:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [AXI_DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic low_power_i,
   input wire logic mux_sequence_done_i,
   input wire logic mux_sequence_running_i,
   input wire logic current_a_done_i,
   input wire logic current_b_done_i,
   input wire msf_fault_det_t fault_detect_i,
   output logic [FLAG_W-1:0] supply_fault_flags_n_o,
   output msf_ctrl_t control_o,
   output logic irq_o
);

   // Word index of a byte address; upper bits must be zero to hit
   function automatic logic [REG_IDX_W:0] addr_to_index(input logic [AXI_ADDR_W-1:0] addr);
      logic hit;
      hit = (addr[AXI_ADDR_W-1:REG_IDX_W+WORD_LSB] == '0);
      return {hit, addr[REG_IDX_W+WORD_LSB-1:WORD_LSB]};
   endfunction : addr_to_index

   // Byte strobes widened to a bit mask
   function automatic logic [AXI_DATA_W-1:0] strb_mask(input logic [AXI_STRB_W-1:0] strb);
      logic [AXI_DATA_W-1:0] m;
      m = WORD_ZERO;
      for (int i = 0; i < AXI_STRB_W; i++) begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction : strb_mask

   function automatic logic is_mapped(input logic [REG_IDX_W:0] idx);
      logic [REG_IDX_W-1:0] w;
      w = idx[REG_IDX_W-1:0];
      return idx[REG_IDX_W] && ((w == IDX_PROGRESS) || (w == IDX_FAULT) ||
         (w == IDX_CONTROL) || (w == IDX_IRQ_STATUS) || (w == IDX_IRQ_MASK));
   endfunction : is_mapped

   // Write channel state
   msf_wr_state_t wr_state_q;
   logic [AXI_ADDR_W-1:0] wr_addr_q;
   logic [AXI_DATA_W-1:0] wr_data_q;
   logic [AXI_STRB_W-1:0] wr_strb_q;
   logic [1:0] bresp_q;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic [AXI_ADDR_W-1:0] wr_addr;
   logic [AXI_DATA_W-1:0] wr_data;
   logic [AXI_DATA_W-1:0] wr_mask;
   logic [REG_IDX_W:0] wr_idx;

   // Read channel state
   msf_rd_state_t rd_state_q;
   logic [AXI_DATA_W-1:0] rdata_q;
   logic [1:0] rresp_q;
   logic ar_take;
   logic [REG_IDX_W:0] rd_idx;
   logic [AXI_DATA_W-1:0] rd_word;

   // Block state
   msf_ctrl_t ctrl_q;
   logic [FLAG_W-1:0] flags_q;
   logic [FLAG_W-1:0] flags_d;
   logic [FLAG_W-1:0] det_vec;
   logic [FLAG_W-1:0] restore_vec;
   logic running_q;
   msf_irq_t irq_status_q;
   msf_irq_t irq_status_d;
   msf_irq_t irq_mask_q;
   msf_irq_t irq_event;
   logic irq_clear;
   logic [CNT_W-1:0] mux_cnt;
   logic [CNT_W-1:0] cur_a_cnt;
   logic [CNT_W-1:0] cur_b_cnt;
   logic quiet;
   logic mux_active;
   logic cur_a_active;
   logic cur_b_active;

   // Write handshake: address and data accepted in either order
   always_comb begin
      s_axi_awready = 1'b0;
      s_axi_wready = 1'b0;
      unique case (wr_state_q)
         WR_IDLE: begin
            s_axi_awready = 1'b1;
            s_axi_wready = 1'b1;
         end
         WR_ADDR: begin
            s_axi_wready = 1'b1;
         end
         WR_DATA: begin
            s_axi_awready = 1'b1;
         end
         WR_RESP: begin
            s_axi_awready = 1'b0;
         end
      endcase
   end

   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take = s_axi_wvalid && s_axi_wready;
   assign wr_fire = ((wr_state_q == WR_IDLE) && aw_take && w_take) ||
      ((wr_state_q == WR_ADDR) && w_take) || ((wr_state_q == WR_DATA) && aw_take);
   assign wr_addr = (wr_state_q == WR_ADDR) ? wr_addr_q : s_axi_awaddr;
   assign wr_data = (wr_state_q == WR_DATA) ? wr_data_q : s_axi_wdata;
   assign wr_mask = strb_mask((wr_state_q == WR_DATA) ? wr_strb_q : s_axi_wstrb);
   assign wr_idx = addr_to_index(wr_addr);

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wr_state_q <= WR_IDLE;
      end else begin
         unique case (wr_state_q)
            WR_IDLE: begin
               if (aw_take && w_take) begin
                  wr_state_q <= WR_RESP;
               end else if (aw_take) begin
                  wr_state_q <= WR_ADDR;
               end else if (w_take) begin
                  wr_state_q <= WR_DATA;
               end
            end
            WR_ADDR: begin
               if (w_take) begin
                  wr_state_q <= WR_RESP;
               end
            end
            WR_DATA: begin
               if (aw_take) begin
                  wr_state_q <= WR_RESP;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state_q <= WR_IDLE;
               end
            end
         endcase
      end
   end

   // Captured halves of a split write
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         wr_addr_q <= '0;
         wr_data_q <= WORD_ZERO;
         wr_strb_q <= '0;
      end else begin
         if (aw_take) begin
            wr_addr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wr_data_q <= s_axi_wdata;
            wr_strb_q <= s_axi_wstrb;
         end
      end
   end

   // Unmapped writes are dropped and answered with an error
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bresp_q <= is_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   assign s_axi_bvalid = (wr_state_q == WR_RESP);
   assign s_axi_bresp = bresp_q;

   // Read channel: one read at a time, data registered
   assign s_axi_arready = (rd_state_q == RD_IDLE);
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign rd_idx = addr_to_index(s_axi_araddr);

   always_comb begin
      rd_word = WORD_ZERO;
      if (rd_idx[REG_IDX_W]) begin
         unique case (rd_idx[REG_IDX_W-1:0])
            IDX_PROGRESS: begin
               rd_word[PROG_MUX_CNT_LSB +: CNT_W] = mux_cnt;
               rd_word[PROG_CUR_A_CNT_LSB +: CNT_W] = cur_a_cnt;
               rd_word[PROG_CUR_B_CNT_LSB +: CNT_W] = cur_b_cnt;
               rd_word[PROG_RUNNING_BIT] = running_q;
            end
            IDX_FAULT: begin
               rd_word[FLAG_W-1:0] = flags_q;
            end
            IDX_CONTROL: begin
               rd_word[CTRL_W-1:0] = ctrl_q;
            end
            IDX_IRQ_STATUS: begin
               rd_word[IRQ_W-1:0] = irq_status_q;
            end
            IDX_IRQ_MASK: begin
               rd_word[IRQ_W-1:0] = irq_mask_q;
            end
            default: begin
               rd_word = WORD_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         rd_state_q <= RD_IDLE;
         rdata_q <= WORD_ZERO;
         rresp_q <= RESP_OKAY;
      end else if (ar_take) begin
         rd_state_q <= RD_RESP;
         rdata_q <= rd_word;
         rresp_q <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if ((rd_state_q == RD_RESP) && s_axi_rready) begin
         rd_state_q <= RD_IDLE;
      end
   end

   assign s_axi_rvalid = (rd_state_q == RD_RESP);
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   // Control register: enables and standby request
   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_fire && wr_idx[REG_IDX_W] && (wr_idx[REG_IDX_W-1:0] == IDX_CONTROL)) begin
         ctrl_q <= (ctrl_q & ~wr_mask[CTRL_W-1:0]) | (wr_data[CTRL_W-1:0] & wr_mask[CTRL_W-1:0]);
      end
   end

   // Mux configuration lives elsewhere; software must drop mux_en first
   // Enable exported
   assign control_o = ctrl_q;

   assign quiet = ctrl_q.standby || low_power_i;
   assign mux_active = ctrl_q.mux_en && !quiet;
   assign cur_a_active = ctrl_q.cur_a_en && !quiet;
   assign cur_b_active = ctrl_q.cur_b_en && !quiet;

   msf_wrap_counter u_mux_cnt (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clear_i(!mux_active),
      .step_i(mux_sequence_done_i),
      .count_o(mux_cnt)
   );

   msf_wrap_counter u_cur_a_cnt (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clear_i(!cur_a_active),
      .step_i(current_a_done_i),
      .count_o(cur_a_cnt)
   );

   msf_wrap_counter u_cur_b_cnt (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .clear_i(!cur_b_active),
      .step_i(current_b_done_i),
      .count_o(cur_b_cnt)
   );

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         running_q <= 1'b0;
      end else begin
         running_q <= mux_sequence_running_i && mux_active;
      end
   end

   // Detector conditions into flag positions
   always_comb begin
      det_vec = '0;
      det_vec[FLT_ANALOG_OV] = fault_detect_i.analog_supply_overvoltage;
      det_vec[FLT_IO_OV] = fault_detect_i.io_supply_overvoltage;
      det_vec[FLT_CORE_OV] = fault_detect_i.core_supply_overvoltage;
      det_vec[FLT_ANALOG_UV] = fault_detect_i.analog_supply_undervoltage;
      det_vec[FLT_IO_UV] = fault_detect_i.io_supply_undervoltage;
      det_vec[FLT_CORE_UV] = fault_detect_i.core_supply_undervoltage;
      det_vec[FLT_ANALOG_OSC] = fault_detect_i.analog_supply_oscillation;
      det_vec[FLT_IO_OSC] = fault_detect_i.io_supply_oscillation;
      det_vec[FLT_CORE_OSC] = fault_detect_i.core_supply_oscillation;
      det_vec[FLT_ANALOG_OTW] = fault_detect_i.analog_regulator_overtemp_warn;
      det_vec[FLT_IO_OTW] = fault_detect_i.io_regulator_overtemp_warn;
      det_vec[FLT_ANALOG_CL] = fault_detect_i.analog_regulator_current_limit;
      det_vec[FLT_IO_CL] = fault_detect_i.io_regulator_current_limit;
      det_vec[FLT_GND_A_OPEN] = fault_detect_i.analog_ground_first_open;
      det_vec[FLT_GND_B_OPEN] = fault_detect_i.analog_ground_second_open;
      det_vec[FLT_DIGITAL_GROUND_OPEN] = fault_detect_i.digital_ground_open;
   end

   assign restore_vec = (wr_fire && wr_idx[REG_IDX_W] &&
      (wr_idx[REG_IDX_W-1:0] == IDX_FAULT)) ?
      (wr_data[FLAG_W-1:0] & wr_mask[FLAG_W-1:0]) : '0;

   // Latched low, live fault beats restore
   assign flags_d = (flags_q | restore_vec) & ~det_vec;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         // All flags read one after reset
         flags_q <= FAULT_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

   assign supply_fault_flags_n_o = flags_q;

   // Events: counted completions and a flag freshly dropping
   always_comb begin
      irq_event.mux_seq_done = mux_sequence_done_i && mux_active;
      irq_event.cur_a_done = current_a_done_i && cur_a_active;
      irq_event.cur_b_done = current_b_done_i && cur_b_active;
      irq_event.fault_new = |(flags_q & det_vec);
   end

   // Read of status clears it; a coincident event survives
   assign irq_clear = ar_take && rd_idx[REG_IDX_W] &&
      (rd_idx[REG_IDX_W-1:0] == IDX_IRQ_STATUS);
   assign irq_status_d = (irq_clear ? msf_irq_t'(IRQ_RESET) : irq_status_q) | irq_event;

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         irq_status_q <= IRQ_RESET;
      end else begin
         irq_status_q <= irq_status_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!resetn_i) begin
         irq_mask_q <= IRQ_RESET;
      end else if (wr_fire && wr_idx[REG_IDX_W] &&
            (wr_idx[REG_IDX_W-1:0] == IDX_IRQ_MASK)) begin
         irq_mask_q <= (irq_mask_q & ~wr_mask[IRQ_W-1:0]) |
            (wr_data[IRQ_W-1:0] & wr_mask[IRQ_W-1:0]);
      end
   end

   // Level output, no extra register to keep latency at one cycle
   assign irq_o = |(irq_status_q & irq_mask_q);

endmodule : msf_top

/* File: dv/msf_top_props.sv */
`timescale 1ns/1ns
module msf_top_props
   import msf_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [AXI_DATA_W-1:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic mux_sequence_running_i,
   input wire msf_fault_det_t fault_detect_i,
   input wire logic [FLAG_W-1:0] supply_fault_flags_n_o,
   input wire msf_ctrl_t control_o,
   input wire logic irq_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   logic rd_take;
   logic prog_take;
   assign rd_take = s_axi_arvalid && s_axi_arready;
   assign prog_take = rd_take && (s_axi_araddr == 12'h008);
   a_flag_drop: assert property ((fault_detect_i != 16'h0000) |=>
      ((supply_fault_flags_n_o & $past(fault_detect_i)) == 16'h0000)) else $error("flag not set");
   // Reset edge excluded, flags jump to ones there
   a_flag_sticky: assert property ($past(resetn_i) &&
      ((supply_fault_flags_n_o & ~$past(supply_fault_flags_n_o)) != 16'h0000)
      |-> $rose(s_axi_bvalid)) else $error("flag restored without write");
   a_rd_latency: assert property (rd_take |=> s_axi_rvalid) else $error("late read data");
   a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("rvalid held after handshake");
   a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("bvalid held after handshake");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read overlap");
   a_cnt_clear: assert property (prog_take && !control_o.mux_en &&
      !$past(control_o.mux_en) |=> s_axi_rdata[15:14] == 2'h0) else $error("counter not clear");
   a_run_idle: assert property (prog_take && !$past(mux_sequence_running_i)
      |=> !s_axi_rdata[1]) else $error("running bit set while idle");
   a_prog_reserved: assert property (prog_take |=> s_axi_rdata[31:16] == 16'h0000 &&
      s_axi_rdata[13:12] == 2'h0 && s_axi_rdata[7:2] == 6'h00 && !s_axi_rdata[0])
      else $error("reserved progress bits set");
   a_unmapped_err: assert property (rd_take && (s_axi_araddr[9:2] > IDX_IRQ_MASK)
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == WORD_ZERO) else $error("bad unmapped read");
   c_irq: cover property ($rose(irq_o));
   c_slverr: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_drop: cover property ($fell(supply_fault_flags_n_o[0]));
endmodule : msf_top_props

bind msf_top msf_top_props u_props (.sys_clk_i, .resetn_i, .s_axi_arvalid, .s_axi_arready,
   .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .mux_sequence_running_i, .fault_detect_i,
   .supply_fault_flags_n_o, .control_o, .irq_o);

/* File: dv/testbench.sv */
`timescale 1ns/1ns
module testbench
   import msf_pkg::*;
;
   logic sys_clk_i, resetn_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [AXI_DATA_W-1:0] s_axi_wdata, s_axi_rdata;
   logic [AXI_STRB_W-1:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic low_power_i, mux_sequence_done_i, mux_sequence_running_i, current_a_done_i;
   logic current_b_done_i, irq_o;
   msf_fault_det_t fault_detect_i;
   logic [FLAG_W-1:0] supply_fault_flags_n_o;
   msf_ctrl_t control_o;
   typedef struct packed {logic [31:0] d; logic [1:0] r;} msf_exp_t;
   msf_exp_t rd_q[$];
   logic [1:0] wr_q[$];
   int bad_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int nm, na, nb;
   logic [15:0] v;
   localparam logic [11:0] A_PROG = {2'h0, IDX_PROGRESS, 2'h0};
   localparam logic [11:0] A_FLT = {2'h0, IDX_FAULT, 2'h0};
   localparam logic [11:0] A_CTRL = {2'h0, IDX_CONTROL, 2'h0};
   localparam logic [11:0] A_IST = {2'h0, IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] A_IMSK = {2'h0, IDX_IRQ_MASK, 2'h0};
   localparam logic [11:0] A_BAD = 12'h100;

   msf_top DUT (.sys_clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
      .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
      .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .low_power_i, .mux_sequence_done_i,
      .mux_sequence_running_i, .current_a_done_i, .current_b_done_i, .fault_detect_i,
      .supply_fault_flags_n_o, .control_o, .irq_o);

   initial begin
      sys_clk_i = 1'h0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      rd_q.push_back('{d, r});
      @(posedge sys_clk_i);
      s_axi_arvalid <= 1'h1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'h1;
      do @(posedge sys_clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'h0;
      do @(posedge sys_clk_i); while (!s_axi_rvalid);
      s_axi_rready <= 1'h0;
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
      logic ga;
      logic gw;
      wr_q.push_back(r);
      ga = 1'h0;
      gw = 1'h0;
      @(posedge sys_clk_i);
      s_axi_awvalid <= 1'h1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'h1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'h1;
      while (!(ga && gw)) begin
         @(posedge sys_clk_i);
         if (s_axi_awready && !ga) begin
            ga = 1'h1;
            s_axi_awvalid <= 1'h0;
         end
         if (s_axi_wready && !gw) begin
            gw = 1'h1;
            s_axi_wvalid <= 1'h0;
         end
      end
      do @(posedge sys_clk_i); while (!s_axi_bvalid);
      s_axi_bready <= 1'h0;
   endtask : wr

   // Done inputs are single-cycle pulses
   task automatic pulse(input logic m, input logic a, input logic b);
      @(posedge sys_clk_i);
      mux_sequence_done_i <= m;
      current_a_done_i <= a;
      current_b_done_i <= b;
      @(posedge sys_clk_i);
      {mux_sequence_done_i, current_a_done_i, current_b_done_i} <= 3'h0;
   endtask : pulse

   task automatic detect(input logic [15:0] f);
      @(posedge sys_clk_i);
      fault_detect_i <= msf_fault_det_t'(f);
      @(posedge sys_clk_i);
      fault_detect_i <= '0;
   endtask : detect

   always @(posedge sys_clk_i) begin : mon
      msf_exp_t e;
      if (s_axi_rvalid && s_axi_rready) begin
         e = rd_q.pop_front();
         check("rdata", s_axi_rdata, e.d);
         check("rresp", {30'h0, s_axi_rresp}, {30'h0, e.r});
      end
      if (s_axi_bvalid && s_axi_bready) begin
         check("bresp", {30'h0, s_axi_bresp}, {30'h0, wr_q.pop_front()});
      end
      cycles++;
      // Whole run needs a few hundred cycles
      if (cycles == 20000) begin
         bad_count++;
         stop_test();
      end
   end

   initial begin
      {resetn_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {low_power_i, mux_sequence_done_i, mux_sequence_running_i} = 3'h0;
      {current_a_done_i, current_b_done_i} = 2'h0;
      fault_detect_i = '0;
      s_axi_wstrb = 4'hF;
      repeat (8) @(posedge sys_clk_i);
      resetn_i <= 1'h1;
      void'($urandom(94));
      rd(A_PROG, WORD_ZERO);
      rd(A_FLT, 32'h0000_FFFF);
      rd(A_CTRL, WORD_ZERO);
      rd(A_IST, WORD_ZERO);
      rd(A_IMSK, WORD_ZERO);
      rd(A_BAD, WORD_ZERO, RESP_SLVERR);
      wr(A_BAD, 32'hFFFF_FFFF, RESP_SLVERR);
      wr(A_PROG, 32'hFFFF_FFFF);
      rd(A_PROG, WORD_ZERO);
      $display("test reset_values done");
      wr(A_CTRL, 32'h0000_0007);
      rd(A_CTRL, 32'h0000_0007);
      check("control_o", {28'h0, control_o}, 32'h0000_0007);
      nm = $urandom_range(9, 4);
      na = $urandom_range(9, 4);
      nb = $urandom_range(9, 4);
      mux_sequence_running_i <= 1'h1;
      for (int i = 0; i < 9; i++) begin
         pulse(i < nm, i < na, i < nb);
      end
      rd(A_PROG, {16'h0, nm[1:0], 2'h0, na[1:0], nb[1:0], 6'h00, 2'h2});
      mux_sequence_running_i <= 1'h0;
      @(posedge sys_clk_i);
      low_power_i <= 1'h1;
      @(posedge sys_clk_i);
      low_power_i <= 1'h0;
      rd(A_PROG, WORD_ZERO);
      pulse(1'h1, 1'h1, 1'h1);
      rd(A_PROG, 32'h0000_4500);
      wr(A_CTRL, WORD_ZERO);
      rd(A_PROG, WORD_ZERO);
      pulse(1'h1, 1'h1, 1'h1);
      rd(A_PROG, WORD_ZERO);
      wr(A_CTRL, 32'h0000_000F);
      pulse(1'h1, 1'h1, 1'h1);
      rd(A_PROG, WORD_ZERO);
      wr(A_CTRL, 32'h0000_0007);
      $display("test counters done");
      for (int i = 0; i < 17; i++) begin
         v = (i < 16) ? (16'h0001 << i) : 16'($urandom());
         detect(v);
         rd(A_FLT, {16'h0, ~v});
         check("flags_o", {16'h0, supply_fault_flags_n_o}, {16'h0, ~v});
         wr(A_FLT, WORD_ZERO);
         rd(A_FLT, {16'h0, ~v});
         wr(A_FLT, {16'h0, v});
         rd(A_FLT, 32'h0000_FFFF);
      end
      // Byte strobe limits the restore to the low byte
      detect(16'h0101);
      s_axi_wstrb <= 4'h1;
      wr(A_FLT, 32'h0000_FFFF);
      s_axi_wstrb <= 4'hF;
      rd(A_FLT, 32'h0000_FEFF);
      @(posedge sys_clk_i);
      fault_detect_i <= msf_fault_det_t'(16'h8001);
      wr(A_FLT, 32'h0000_FFFF);
      rd(A_FLT, 32'h0000_7FFE);
      @(posedge sys_clk_i);
      fault_detect_i <= '0;
      wr(A_FLT, 32'h0000_FFFF);
      rd(A_FLT, 32'h0000_FFFF);
      $display("test fault_flags done");
      rd(A_IST, 32'h0000_000F);
      rd(A_IST, WORD_ZERO);
      wr(A_IMSK, 32'h0000_0001);
      pulse(1'h0, 1'h1, 1'h0);
      repeat (2) @(posedge sys_clk_i);
      check("irq_masked", {31'h0, irq_o}, WORD_ZERO);
      pulse(1'h1, 1'h0, 1'h0);
      repeat (2) @(posedge sys_clk_i);
      check("irq_raised", {31'h0, irq_o}, 32'h0000_0001);
      rd(A_IST, 32'h0000_0003);
      check("irq_cleared", {31'h0, irq_o}, WORD_ZERO);
      $display("test interrupts done");
      stop_test();
   end
endmodule : testbench
